// ---- core/pidst_supervisor.sv ----
// four-channel self-tune supervisor with its AXI4-Lite buffer words
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "pidst_map.svh"

module pidst_supervisor #(
    parameter logic [39:0] TIMEOUT_CYC = 40'(`TUNE_LIMIT_S * `CLK_HZ)
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pidst_pkg::pidst_ch_in_s [3:0] ch_in,
    input wire logic hw_fail,
    output logic [3:0] at_active_flag,
    output pidst_pkg::pidst_resp_e [3:0] resp_level
);

    pidst_pkg::pidst_state_s s;
    pidst_pkg::pidst_state_s next_s;
    pidst_pkg::pidst_dec_s wdec;
    pidst_pkg::pidst_dec_s rdec;
    logic [31:0] old_val;
    logic [31:0] rd_val;
    logic [15:0] merged;
    logic [3:0] wfail;
    logic fail;
    logic [15:0] ra;

    function automatic logic [9:0] word_index(input logic [4:0] rid, input logic [1:0] ch);
        logic [9:0] base;
        logic [9:0] step;
        base = 10'h000;
        step = `STEP_MAIN;
        case (rid)
            `RID_TARGET: base = `OFF_TARGET;
            `RID_PROP: base = `OFF_PROP;
            `RID_INTEG: base = `OFF_INTEG;
            `RID_DERIV: base = `OFF_DERIV;
            `RID_OUP: base = `OFF_OUP;
            `RID_OLO: base = `OFF_OLO;
            `RID_TUP: base = `OFF_TUP;
            `RID_TLO: base = `OFF_TLO;
            `RID_PERIOD: base = `OFF_PERIOD;
            `RID_SMOOTH: base = `OFF_SMOOTH;
            `RID_RESP: base = `OFF_RESP;
            `RID_AUTOMAN: base = `OFF_AUTOMAN;
            `RID_DIR: base = `OFF_DIR;
            `RID_LBT: base = `OFF_LBT;
            `RID_CUP: begin
                base = `OFF_CUP;
                step = `STEP_COOL;
            end
            `RID_CPER: begin
                base = `OFF_CPER;
                step = `STEP_COOL;
            end
            `RID_SENS: begin
                base = `OFF_SENS;
                step = `STEP_SENS;
            end
            `RID_BIAS: begin
                base = `OFF_BIAS;
                step = `STEP_BIAS;
            end
            default: base = 10'h000;
        endcase
        return 10'(base + step * {8'h00, ch});
    endfunction

    function automatic pidst_pkg::pidst_dec_s decode(input logic [9:0] idx);
        pidst_pkg::pidst_dec_s d;
        d = '0;
        d.ctrl = (idx == `OFF_CTRL);
        d.stat = (idx == `OFF_STATUS);
        d.junc = (idx == `OFF_JUNC);
        for (int c = 0; c < 4; c++) begin
            for (int r = 0; r < `NUM_RID; r++) begin
                if (idx == word_index(5'(r), 2'(c))) begin
                    d.hit = 1'b1;
                    d.ch = 2'(c);
                    d.rid = 5'(r);
                end
            end
        end
        return d;
    endfunction

    function automatic logic mapped(input pidst_pkg::pidst_dec_s d);
        return d.hit | d.junc | d.ctrl | d.stat;
    endfunction

    // words whose change spoils the measurement under way
    function automatic logic watched(input logic [4:0] rid);
        logic w;
        w = 1'b0;
        case (rid)
            `RID_TARGET, `RID_OUP, `RID_OLO, `RID_CUP, `RID_PERIOD, `RID_CPER,
            `RID_SMOOTH, `RID_AUTOMAN, `RID_DIR, `RID_SENS, `RID_BIAS: w = 1'b1;
            default: w = 1'b0;
        endcase
        return w;
    endfunction

    function automatic logic [31:0] reg_value(input pidst_pkg::pidst_state_s st,
                                              input pidst_pkg::pidst_dec_s d);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (d.ctrl) begin
            v[15:0] = st.ctrl;
        end else if (d.stat) begin
            v[`STAT_ACT_LSB +: 4] = st.active;
            v[`STAT_FAIL_LSB +: 4] = st.failed;
            v[`STAT_PASS_LSB +: 4] = st.passed;
        end else if (d.junc) begin
            v[15:0] = st.junction;
        end else if (d.hit) begin
            v[15:0] = st.word[d.ch][d.rid];
        end
        return v;
    endfunction

    // unknown codes fall back to the middle level
    function automatic pidst_pkg::pidst_resp_e resp_of(input logic [15:0] w);
        pidst_pkg::pidst_resp_e r;
        case (w)
            `RESP_SLOW: r = pidst_pkg::PIDST_SLOW;
            `RESP_FAST: r = pidst_pkg::PIDST_FAST;
            default: r = pidst_pkg::PIDST_NORMAL;
        endcase
        return r;
    endfunction

    function automatic logic calc_ok(input pidst_pkg::pidst_ch_in_s ci);
        logic ok;
        ok = 1'b1;
        if (ci.calc_p < `P_MIN || ci.calc_p > `P_MAX) ok = 1'b0;
        if (ci.calc_i < `I_MIN || ci.calc_i > `I_MAX) ok = 1'b0;
        if (ci.calc_d > `D_MAX) ok = 1'b0;
        return ok;
    endfunction

    assign wdec = decode(s.aw_addr[11:2]);
    assign rdec = decode(s_axi_araddr[11:2]);
    assign old_val = reg_value(s, wdec);
    assign rd_val = reg_value(s, rdec);

    always_comb begin
        next_s = s;
        wfail = 4'h0;
        merged = old_val[15:0];
        fail = 1'b0;
        ra = 16'h0000;

        // write address and data are taken in either order
        if (s.awready && s_axi_awvalid) begin
            next_s.aw_hold = 1'b1;
            next_s.awready = 1'b0;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s.wready && s_axi_wvalid) begin
            next_s.w_hold = 1'b1;
            next_s.wready = 1'b0;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
            next_s.aw_hold = 1'b0;
            next_s.w_hold = 1'b0;
            next_s.awready = 1'b1;
            next_s.wready = 1'b1;
        end

        if (s.aw_hold && s.w_hold && !s.bvalid) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = mapped(wdec) ? `RESP_OKAY : `RESP_SLVERR;
            if (s.w_strb[0]) merged[7:0] = s.w_data[7:0];
            if (s.w_strb[1]) merged[15:8] = s.w_data[15:8];
            if (wdec.ctrl) next_s.ctrl = merged;
            if (wdec.junc) begin
                next_s.junction = merged;
                // the compensation choice is shared, so it spoils every channel
                if (merged != s.junction) wfail = 4'hF;
            end
            if (wdec.hit) begin
                next_s.word[wdec.ch][wdec.rid] = merged;
                if (watched(wdec.rid) && merged != old_val[15:0]) wfail[wdec.ch] = 1'b1;
                if (wdec.rid == `RID_TUP &&
                    $signed(s.word[wdec.ch][`RID_TARGET]) > $signed(merged)) wfail[wdec.ch] = 1'b1;
                if (wdec.rid == `RID_TLO &&
                    $signed(s.word[wdec.ch][`RID_TARGET]) < $signed(merged)) wfail[wdec.ch] = 1'b1;
                // one word serves as proportional or heating band
                if (wdec.rid == `RID_PROP && merged == 16'h0000) wfail[wdec.ch] = 1'b1;
            end
        end

        if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
            next_s.arready = 1'b1;
        end else if (s.arready && s_axi_arvalid) begin
            next_s.rvalid = 1'b1;
            next_s.arready = 1'b0;
            next_s.rdata = rd_val;
            next_s.rresp = mapped(rdec) ? `RESP_OKAY : `RESP_SLVERR;
        end

        for (int c = 0; c < 4; c++) begin
            next_s.req_q[c] = s.ctrl[`CTRL_REQ_LSB + c];
            // level only picks the setpoint shaping; constants stay put
            next_s.resp[c] = resp_of(s.word[c][`RID_RESP]);
            ra = ch_in[c].range_alarm_word;
            unique case (s.run[c])
                pidst_pkg::PIDST_IDLE: begin
                    if (s.ctrl[`CTRL_REQ_LSB + c] && !s.req_q[c]) begin
                        next_s.run[c] = pidst_pkg::PIDST_RUN;
                        next_s.active[c] = 1'b1;
                        next_s.timer[c] = 40'h00_0000_0000;
                        next_s.lbt_zero[c] = (s.word[c][`RID_LBT] == 16'h0000);
                        next_s.failed[c] = 1'b0;
                        next_s.passed[c] = 1'b0;
                    end
                end
                pidst_pkg::PIDST_RUN: begin
                    // one timer covers first approach and each half swing
                    if (ch_in[c].pv_cross) begin
                        next_s.timer[c] = 40'h00_0000_0000;
                    end else begin
                        next_s.timer[c] = s.timer[c] + 40'h00_0000_0001;
                    end
                    fail = wfail[c]
                        | ra[`RANGE_HI_BIT] | ra[`RANGE_LO_BIT]
                        | hw_fail
                        | s.ctrl[`CTRL_HALT_LSB + c]
                        | (s.timer[c] >= TIMEOUT_CYC);
                    // leaving the run state makes later events inert
                    if (fail) begin
                        next_s.run[c] = pidst_pkg::PIDST_IDLE;
                        next_s.active[c] = 1'b0;
                        next_s.failed[c] = 1'b1;
                    end else if (ch_in[c].calc_done) begin
                        next_s.run[c] = pidst_pkg::PIDST_IDLE;
                        next_s.active[c] = 1'b0;
                        if (calc_ok(ch_in[c])) begin
                            next_s.passed[c] = 1'b1;
                            next_s.word[c][`RID_PROP] = ch_in[c].calc_p;
                            next_s.word[c][`RID_INTEG] = ch_in[c].calc_i;
                            next_s.word[c][`RID_DERIV] = ch_in[c].calc_d;
                            if (!s.lbt_zero[c]) begin
                                next_s.word[c][`RID_LBT] = {ch_in[c].calc_i[14:0], 1'b0};
                            end
                        end else begin
                            next_s.failed[c] = 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bresp = s.bresp;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_arready = s.arready;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign s_axi_rvalid = s.rvalid;
    assign at_active_flag = s.active;
    assign resp_level = s.resp;

endmodule

// ---- include/pidst_map.svh ----
// register indices, field positions, reset values and timing counts of the tuning supervisor
`ifndef PIDST_MAP_SVH
`define PIDST_MAP_SVH
`define OFF_TARGET 10'h101
`define OFF_PROP 10'h102
`define OFF_INTEG 10'h103
`define OFF_DERIV 10'h104
`define OFF_OUP 10'h105
`define OFF_OLO 10'h106
`define OFF_TUP 10'h10A
`define OFF_TLO 10'h10B
`define OFF_PERIOD 10'h10C
`define OFF_SMOOTH 10'h10D
`define OFF_RESP 10'h10F
`define OFF_AUTOMAN 10'h113
`define OFF_DIR 10'h115
`define OFF_LBT 10'h116
`define OFF_CUP 10'h1C5
`define OFF_CPER 10'h1C6
`define OFF_SENS 10'h280
`define OFF_BIAS 10'h2A1
`define OFF_JUNC 10'h1E9
`define OFF_CTRL 10'h010
`define OFF_STATUS 10'h011
`define STEP_MAIN 10'h030
`define STEP_COOL 10'h005
`define STEP_SENS 10'h001
`define STEP_BIAS 10'h002
`define RID_TARGET 5'h00
`define RID_PROP 5'h01
`define RID_INTEG 5'h02
`define RID_DERIV 5'h03
`define RID_OUP 5'h04
`define RID_OLO 5'h05
`define RID_TUP 5'h06
`define RID_TLO 5'h07
`define RID_PERIOD 5'h08
`define RID_SMOOTH 5'h09
`define RID_RESP 5'h0A
`define RID_AUTOMAN 5'h0B
`define RID_DIR 5'h0C
`define RID_LBT 5'h0D
`define RID_CUP 5'h0E
`define RID_CPER 5'h0F
`define RID_SENS 5'h10
`define RID_BIAS 5'h11
`define NUM_RID 18
`define CTRL_REQ_LSB 0
`define CTRL_HALT_LSB 4
`define STAT_ACT_LSB 0
`define STAT_FAIL_LSB 4
`define STAT_PASS_LSB 8
`define RANGE_HI_BIT 0
`define RANGE_LO_BIT 1
`define P_MIN 16'h0001
`define P_MAX 16'h2710
`define I_MIN 16'h0001
`define I_MAX 16'h0E10
`define D_MAX 16'h0E10
`define RST_WORD 16'h0000
`define RST_CTRL 16'h0000
`define RESP_SLOW 16'h0000
`define RESP_FAST 16'h0002
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define TUNE_LIMIT_S 64'h0000_0000_0000_1C20
`define CLK_HZ 64'h0000_0000_05F5_E100
`endif

// ---- include/pidst_pkg.sv ----
// types of the tuning supervisor
package pidst_pkg;
    typedef enum logic {PIDST_IDLE, PIDST_RUN} pidst_run_e;
    typedef enum logic [1:0] {PIDST_SLOW, PIDST_NORMAL, PIDST_FAST} pidst_resp_e;
    typedef struct packed {
        logic [15:0] range_alarm_word;
        logic pv_cross;
        logic calc_done;
        logic [15:0] calc_p;
        logic [15:0] calc_i;
        logic [15:0] calc_d;
    } pidst_ch_in_s;
    typedef struct packed {
        logic hit;
        logic junc;
        logic ctrl;
        logic stat;
        logic [1:0] ch;
        logic [4:0] rid;
    } pidst_dec_s;
    typedef struct packed {
        logic [3:0][17:0][15:0] word;
        logic [15:0] junction;
        logic [15:0] ctrl;
        pidst_run_e [3:0] run;
        logic [3:0][39:0] timer;
        logic [3:0] lbt_zero;
        logic [3:0] req_q;
        logic [3:0] failed;
        logic [3:0] passed;
        logic [3:0] active;
        pidst_resp_e [3:0] resp;
        logic awready;
        logic wready;
        logic aw_hold;
        logic w_hold;
        logic [11:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pidst_state_s;
endpackage

// ---- sim/pidst_engine_model.sv ----
// control engine model: range alarms, crossings and tuning results
`timescale 1ns/1ps
module pidst_engine_model (
    input wire logic aclk,
    input wire logic [1:0] sel,
    input wire logic calc_req,
    input wire logic cross_req,
    input wire logic [1:0] alarm,
    input wire logic [47:0] pid,
    output pidst_pkg::pidst_ch_in_s [3:0] ch_in
);
    logic [15:0] junk = 16'h5A3C;
    initial ch_in = '0;
    always @(posedge aclk) begin
        // results outside the done pulse are noise, never a stale copy
        junk <= {junk[14:0], junk[15] ^ junk[12]};
        for (int c = 0; c < 4; c++) begin
            ch_in[c] <= {16'h0, 2'h0, junk, ~junk, junk ^ 16'h0FF0};
            if (sel == 2'(c)) begin
                ch_in[c].range_alarm_word <= {14'h0, alarm};
                ch_in[c].pv_cross <= cross_req;
                ch_in[c].calc_done <= calc_req;
                if (calc_req) begin
                    {ch_in[c].calc_p, ch_in[c].calc_i, ch_in[c].calc_d} <= pid;
                end
            end
        end
    end
endmodule

// ---- sim/pidst_supervisor_props.sv ----
// port checker of the tuning supervisor
`timescale 1ns/1ps
module pidst_supervisor_props #(
    parameter logic [39:0] TIMEOUT_CYC = 40'h3E8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire pidst_pkg::pidst_ch_in_s [3:0] ch_in,
    input wire logic hw_fail,
    input wire logic [3:0] at_active_flag
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // channel 0 run time since start or last crossing
    logic [39:0] quiet;
    always_ff @(posedge aclk) begin
        if (!aresetn || !at_active_flag[0] || ch_in[0].pv_cross) begin
            quiet <= 40'h0;
        end else begin
            quiet <= quiet + 40'h1;
        end
    end
    property p_rst;
        disable iff (1'b0) !aresetn |=> at_active_flag == 4'h0 && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    property p_hi;
        at_active_flag[0] && ch_in[0].range_alarm_word[0] |=> !at_active_flag[0];
    endproperty
    property p_lo;
        at_active_flag[0] && ch_in[0].range_alarm_word[1] |=> !at_active_flag[0];
    endproperty
    property p_hw;
        hw_fail && at_active_flag != 4'h0 |=> at_active_flag == 4'h0;
    endproperty
    property p_calc;
        at_active_flag[3] && ch_in[3].calc_done |=> !at_active_flag[3];
    endproperty
    // a run may only end for a cause seen at the ports
    property p_fall;
        $fell(at_active_flag[0]) |-> $past(ch_in[0].calc_done) || $past(hw_fail)
            || $past(ch_in[0].range_alarm_word[0]) || $past(ch_in[0].range_alarm_word[1])
            || $past(s_axi_bvalid) || s_axi_bvalid || quiet >= TIMEOUT_CYC - 40'h3;
    endproperty
    property p_tmo;
        quiet <= TIMEOUT_CYC + 40'h3;
    endproperty
    property p_start;
        $rose(at_active_flag[0]) |-> $past(s_axi_bvalid);
    endproperty
    property p_bwait;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    property p_bdone;
        s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready && !s_axi_bvalid;
    endproperty
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:16] == 16'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("flag or response set after reset");
    a_hi: assert property (p_hi) else $error("upper range alarm did not end the run");
    a_lo: assert property (p_lo) else $error("lower range alarm did not end the run");
    a_hw: assert property (p_hw) else $error("hardware failure left a run active");
    a_calc: assert property (p_calc) else $error("run still active after result");
    a_fall: assert property (p_fall) else $error("run ended without cause");
    a_tmo: assert property (p_tmo) else $error("run outlived the settling limit");
    a_start: assert property (p_start) else $error("run started without a register write");
    a_bwait: assert property (p_bwait) else $error("write response late");
    a_bdone: assert property (p_bdone) else $error("write channel not freed");
    a_rd: assert property (p_rd) else $error("read answer wrong or late");
    c_pass: cover property ($fell(at_active_flag[0]) && $past(ch_in[0].calc_done));
    c_hw: cover property (hw_fail && at_active_flag[1]);
    c_range: cover property (at_active_flag[0] && ch_in[0].range_alarm_word[0]);
endmodule
bind pidst_supervisor pidst_supervisor_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_props (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .ch_in, .hw_fail, .at_active_flag
);

// ---- sim/test_pid_self_tune_supervisor.sv ----
// self-checking bench of the tuning supervisor
`timescale 1ns/1ps
`include "pidst_map.svh"
module test_pid_self_tune_supervisor;
    localparam logic [39:0] TOUT = 40'h3E8;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
    logic [31:0] s_axi_rdata, rv;
    logic hw_fail = 1'b0, calc_req = 1'b0, cross_req = 1'b0;
    logic [1:0] sel = 2'h0, alarm = 2'h0;
    logic [47:0] pid = 48'h0;
    pidst_pkg::pidst_ch_in_s [3:0] ch_in;
    logic [3:0] at_active_flag;
    pidst_pkg::pidst_resp_e [3:0] resp_level;
    logic [15:0] ctrl = 16'h0;
    int err_total = 0, n_checks = 0, cyc = 0;
    always #5 aclk = ~aclk;
    pidst_supervisor #(.TIMEOUT_CYC(TOUT)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .ch_in, .hw_fail, .at_active_flag, .resp_level);
    pidst_engine_model u_eng (.aclk, .sel, .calc_req, .cross_req, .alarm, .pid, .ch_in);
    task automatic give_verdict();
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [9:0] ix(input logic [9:0] b, input int c);
        return b + `STEP_MAIN * 10'(c);
    endfunction
    task automatic wr(input logic [9:0] a, input logic [15:0] v);
        @(posedge aclk);
        s_axi_awaddr <= {a, 2'h0};
        s_axi_wdata <= {16'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        br = s_axi_bresp;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge aclk);
        s_axi_araddr <= {a, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    // request bit must go low then high; channel 0 halt (bit 4) released on the way
    task automatic go(input int c);
        ctrl[c] = 1'b0;
        ctrl[4] = 1'b0;
        wr(`OFF_CTRL, ctrl);
        ctrl[c] = 1'b1;
        wr(`OFF_CTRL, ctrl);
        repeat (2) @(posedge aclk);
        chk(at_active_flag[c], 1'b1);
    endtask
    task automatic calc(input logic [1:0] c, input logic [47:0] v);
        @(posedge aclk);
        sel <= c;
        pid <= v;
        calc_req <= 1'b1;
        @(posedge aclk);
        calc_req <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic s_regs();
        rd(ix(`OFF_TARGET, 3));
        chk(rv, 32'h0);
        wr(`OFF_SENS + 10'h1, 16'hA5A5);
        chk(32'(br), 32'(`RESP_OKAY));
        rd(`OFF_SENS + 10'h1);
        chk(rv, 32'h0000A5A5);
        chk(32'(rr), 32'(`RESP_OKAY));
        wr(10'h3FF, 16'h1234);
        chk(32'(br), 32'(`RESP_SLVERR));
        rd(10'h3FF);
        chk(rv, 32'h0);
        chk(32'(rr), 32'(`RESP_SLVERR));
    endtask
    task automatic s_pass(input int c, input logic [15:0] lbt0, input logic [47:0] v, input logic [15:0] lbt);
        wr(ix(`OFF_LBT, c), lbt0);
        go(c);
        calc(2'(c), v);
        chk(at_active_flag[c], 1'b0);
        rd(ix(`OFF_PROP, c));
        chk(rv, {16'h0, v[47:32]});
        rd(ix(`OFF_INTEG, c));
        chk(rv, {16'h0, v[31:16]});
        rd(ix(`OFF_DERIV, c));
        chk(rv, {16'h0, v[15:0]});
        rd(ix(`OFF_LBT, c));
        chk(rv, {16'h0, lbt});
        rd(`OFF_STATUS);
        chk(rv[8 + c], 1'b1);
    endtask
    task automatic s_badcalc();
        logic [47:0] bad [5] = '{48'h0000_0005_0005, 48'h2711_0005_0005, 48'h0005_0000_0005,
            48'h0005_0E11_0005, 48'h0005_0005_0E11};
        foreach (bad[k]) begin
            go(3);
            calc(2'h3, bad[k]);
            chk(at_active_flag[3], 1'b0);
            rd(ix(`OFF_DERIV, 3));
            chk(rv, 32'h0);
            rd(`OFF_STATUS);
            chk(rv[7], 1'b1);
        end
    endtask
    // channel 1 keeps tuning until a shared cause hits it
    task automatic s_events();
        sel <= 2'h0;
        go(1);
        for (int k = 0; k < 8; k++) begin
            go(0);
            case (k)
                0: wr(`OFF_TARGET, 16'h0005);
                1: alarm <= 2'h1;
                2: alarm <= 2'h2;
                3: begin
                    ctrl[4] = 1'b1;
                    wr(`OFF_CTRL, ctrl);
                end
                4: wr(`OFF_PROP, 16'h0000);
                5: wr(`OFF_TUP, 16'hFFFF);
                6: hw_fail <= 1'b1;
                default: wr(`OFF_JUNC, 16'h0001);
            endcase
            repeat (3) @(posedge aclk);
            chk(at_active_flag[0], 1'b0);
            chk(at_active_flag[1], 32'(k < 6));
            alarm <= 2'h0;
            hw_fail <= 1'b0;
            calc(2'h0, 48'h0007_0007_0007);
            rd(`OFF_PROP);
            chk(rv, (k >= 4) ? 32'h0 : 32'h2710);
            chk(at_active_flag[0], 1'b0);
        end
    endtask
    task automatic s_resp();
        for (int v = 0; v < 4; v++) begin
            wr(`OFF_RESP, 16'(v));
            repeat (2) @(posedge aclk);
            chk(32'(resp_level[0]), (v == 0) ? 32'h0 : (v == 2) ? 32'h2 : 32'h1);
        end
        rd(`OFF_PROP);
        chk(rv, 32'h0);
    endtask
    task automatic s_time();
        go(0);
        repeat (3) begin
            repeat (900) @(posedge aclk);
            cross_req <= 1'b1;
            @(posedge aclk);
            cross_req <= 1'b0;
        end
        repeat (990) @(posedge aclk);
        chk(at_active_flag[0], 1'b1);
        repeat (20) @(posedge aclk);
        chk(at_active_flag[0], 1'b0);
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        s_regs();
        s_pass(0, 16'h0005, {16'h2710, 16'h0E10, 16'h0000}, 16'h1C20);
        s_pass(2, 16'h0000, {16'h0001, 16'h0001, 16'h0E10}, 16'h0000);
        s_badcalc();
        s_events();
        s_resp();
        s_time();
        give_verdict();
    end
endmodule
